// file: src/boot_strap_bus_width_config.v
// boot strap capture, configuration decode and expansion data lane control
`timescale 1ns/10ps

// Overview of operation
// - drive strength low/medium/high chosen from config bits 9 and 5.
// - pci clock bit 0 selects 33 MHz, 1 selects 66 MHz.
// - arbiter bit from address line 2 enables internal pci arbiter.
// - host bit from address line 1 makes device pci host.
// - width pair b7,b0: 00 16-bit, 01 8-bit, 11 32-bit, 10 reserved.
// - width in use comes from config bits 0 and 7 unless chip select control bit 2 selects the software override width.
// - width latched on first clock edge after reset release; o_bus_width holds 32-bit until one cycle later.
// - bits 0 and 7 forced to 1 while reset asserted.
// - byte mode drives lines 31:8 on writes, tristates them on reads.
// - 16-bit mode drives lines 31:16 on writes, tristates on reads.
module boot_strap_bus_width_config #(
	parameter AW = 24,
	parameter DW = 32
) (
	input wire i_core_clk,
	input wire i_rst_n,
	input wire [AW-1:0] i_exp_address_lines,
	input wire [7:0] i_reg_addr,
	input wire [31:0] i_reg_wdata,
	input wire i_reg_wr,
	input wire i_reg_rd,
	output reg [31:0] o_reg_rdata,
	input wire i_exp_cycle,
	input wire i_exp_write,
	input wire [DW-1:0] i_exp_wdata,
	output wire [DW-1:0] o_exp_data_lines_out,
	output wire [DW-1:0] o_exp_data_lines_oe,
	output reg [1:0] o_bus_width,
	output reg [1:0] o_drive_strength,
	output reg o_pci_66mhz,
	output reg [6:0] o_pci_clk_mhz,
	output reg o_pci_arbiter_enable,
	output reg o_pci_host
);

`include "boot_strap_regs.vh"

	// capture sequencer states
	localparam ST_HOLD = 2'b00;
	localparam ST_DECODE = 2'b01;
	localparam ST_RUN = 2'b10;

	// strap synchroniser, left out of reset so the pins are sampled while reset is held
	reg [AW-1:0] strap_s1_r;
	reg [AW-1:0] strap_s2_r;

	// capture sequencer
	reg [1:0] cap_state_r;
	reg [1:0] cap_state_nxt;
	wire cap_load;

	// configuration and chip select control registers
	reg [31:0] boot_strap_config_r;
	reg [31:0] config_nxt;
	reg [2:0] csctl_r;
	reg [2:0] csctl_nxt;

	// register bus decode
	wire csctl_wr;
	wire sel_cfg;
	wire sel_csctl;
	wire sel_status;
	reg [31:0] rdata_nxt;

	// configuration fields
	wire cfg_width_low;
	wire cfg_width_high;
	wire cfg_host;
	wire cfg_arb;
	wire cfg_pci_clk;
	wire cfg_drv_low;
	wire cfg_drv_high;
	wire [1:0] strap_width;
	wire [1:0] drive_sel;
	wire width_override;
	wire [1:0] override_width;

	// decoded values
	reg [1:0] width_nxt;
	reg [1:0] drive_nxt;
	reg pci_66mhz_nxt;
	reg [6:0] pci_clk_mhz_nxt;
	reg arbiter_nxt;
	reg host_nxt;
	wire reserved_width;
	wire [31:0] status;

	// two-flop sync of strap pins; the first flop feeds only the second
	always @(posedge i_core_clk) begin
		strap_s1_r <= i_exp_address_lines;
		strap_s2_r <= strap_s1_r;
	end

	// capture sequencer: hold in reset, capture on first edge after release, then decode, then run
	always @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cap_state_r <= ST_HOLD;
		end else begin
			cap_state_r <= cap_state_nxt;
		end
	end

	always @* begin
		cap_state_nxt = cap_state_r;
		case (cap_state_r)
			ST_HOLD: begin
				cap_state_nxt = ST_DECODE;
			end
			ST_DECODE: begin
				cap_state_nxt = ST_RUN;
			end
			ST_RUN: begin
				cap_state_nxt = ST_RUN;
			end
			default: begin
				cap_state_nxt = ST_RUN;
			end
		endcase
	end

	// one capture per reset, so later strap movement is ignored
	assign cap_load = (cap_state_r == ST_HOLD);

	always @* begin
		config_nxt = boot_strap_config_r;
		if (cap_load) begin
			config_nxt = {{(32-AW){1'b0}}, strap_s2_r};
		end
	end

	// configuration register, all ones while reset is held
	always @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			boot_strap_config_r <= `CFG0_RESET;
		end else begin
			boot_strap_config_r <= config_nxt;
		end
	end

	// chip select control register written by software after boot
	assign csctl_wr = i_reg_wr && (i_reg_addr == `CSCTL_OFFSET);

	always @* begin
		csctl_nxt = csctl_r;
		if (csctl_wr) begin
			csctl_nxt = i_reg_wdata[2:0];
		end
	end

	always @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			csctl_r <= 3'b000;
		end else begin
			csctl_r <= csctl_nxt;
		end
	end

	// configuration fields
	assign cfg_width_low = boot_strap_config_r[`BIT_WIDTH_LOW];
	assign cfg_width_high = boot_strap_config_r[`BIT_WIDTH_HIGH];
	assign cfg_host = boot_strap_config_r[`BIT_HOST];
	assign cfg_arb = boot_strap_config_r[`BIT_ARB];
	assign cfg_pci_clk = boot_strap_config_r[`BIT_PCI_CLK];
	assign cfg_drv_low = boot_strap_config_r[`BIT_DRV_LOW];
	assign cfg_drv_high = boot_strap_config_r[`BIT_DRV_HIGH];

	assign strap_width = {cfg_width_high, cfg_width_low};
	assign drive_sel = {cfg_drv_high, cfg_drv_low};
	assign width_override = csctl_r[`CSCTL_OVR_BIT];
	assign override_width = csctl_r[`CSCTL_WIDTH_LSB +: 2];

	// width in use: strapped value until software overrides it
	always @* begin
		width_nxt = strap_width;
		if (width_override) begin
			width_nxt = override_width;
		end
	end

	// drive strength; the unlisted pair 10 is taken as high
	always @* begin
		case (drive_sel)
			2'b00: drive_nxt = `DRIVE_LOW;
			2'b01: drive_nxt = `DRIVE_MED;
			default: drive_nxt = `DRIVE_HIGH;
		endcase
	end

	always @* begin
		pci_66mhz_nxt = cfg_pci_clk;
		if (cfg_pci_clk) begin
			pci_clk_mhz_nxt = `PCI_66_MHZ;
		end else begin
			pci_clk_mhz_nxt = `PCI_33_MHZ;
		end
	end

	always @* begin
		arbiter_nxt = cfg_arb;
		host_nxt = cfg_host;
	end

	// decoded configuration outputs
	always @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_bus_width <= `WIDTH_32;
		end else begin
			o_bus_width <= width_nxt;
		end
	end

	always @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_drive_strength <= `DRIVE_HIGH;
		end else begin
			o_drive_strength <= drive_nxt;
		end
	end

	always @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pci_66mhz <= 1'b1;
		end else begin
			o_pci_66mhz <= pci_66mhz_nxt;
		end
	end

	always @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pci_clk_mhz <= `PCI_66_MHZ;
		end else begin
			o_pci_clk_mhz <= pci_clk_mhz_nxt;
		end
	end

	always @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pci_arbiter_enable <= 1'b1;
		end else begin
			o_pci_arbiter_enable <= arbiter_nxt;
		end
	end

	always @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pci_host <= 1'b1;
		end else begin
			o_pci_host <= host_nxt;
		end
	end

	// status: reserved width flag, drive strength, width in use
	assign reserved_width = (o_bus_width == `WIDTH_RSVD);
	assign status = {27'h000_0000, reserved_width, o_drive_strength, o_bus_width};

	// register read decode; unmapped addresses read as zero
	assign sel_cfg = (i_reg_addr == `CFG0_OFFSET);
	assign sel_csctl = (i_reg_addr == `CSCTL_OFFSET);
	assign sel_status = (i_reg_addr == `STATUS_OFFSET);

	always @* begin
		rdata_nxt = 32'h0000_0000;
		if (i_reg_rd) begin
			if (sel_cfg) begin
				rdata_nxt = boot_strap_config_r;
			end else if (sel_csctl) begin
				rdata_nxt = {29'h0000_0000, csctl_r};
			end else if (sel_status) begin
				rdata_nxt = status;
			end
		end
	end

	// read data stands for the one cycle after the strobe
	always @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_reg_rdata <= 32'h0000_0000;
		end else begin
			o_reg_rdata <= rdata_nxt;
		end
	end

	lane_ctrl #(
		.DW(DW)
	) u_lane_ctrl (
		.i_width(o_bus_width),
		.i_write(i_exp_write),
		.i_active(i_exp_cycle),
		.i_wdata(i_exp_wdata),
		.o_data_out(o_exp_data_lines_out),
		.o_data_oe(o_exp_data_lines_oe)
	);

endmodule // boot_strap_bus_width_config

// file: pkg/boot_strap_regs.vh
// register offsets, field positions, reset values and widths for the boot strap block
`ifndef BOOT_STRAP_REGS_VH
`define BOOT_STRAP_REGS_VH

`define CFG0_OFFSET 8'h00
`define CSCTL_OFFSET 8'h04
`define STATUS_OFFSET 8'h08

`define CFG0_RESET 32'hFFFF_FFFF

`define BIT_WIDTH_LOW 0
`define BIT_HOST 1
`define BIT_ARB 2
`define BIT_PCI_CLK 4
`define BIT_DRV_LOW 5
`define BIT_WIDTH_HIGH 7
`define BIT_DRV_HIGH 9

`define WIDTH_16 2'b00
`define WIDTH_8 2'b01
`define WIDTH_RSVD 2'b10
`define WIDTH_32 2'b11

`define DRIVE_LOW 2'b00
`define DRIVE_MED 2'b01
`define DRIVE_HIGH 2'b11

`define CSCTL_WIDTH_LSB 0
`define CSCTL_OVR_BIT 2

`define PCI_33_MHZ 7'h21
`define PCI_66_MHZ 7'h42

`endif

// file: src/lane_ctrl.v
// upper data lane drive control for byte and 16-bit modes
`timescale 1ns/10ps

module lane_ctrl #(
	parameter DW = 32
) (
	input wire [1:0] i_width,
	input wire i_write,
	input wire i_active,
	input wire [DW-1:0] i_wdata,
	output wire [DW-1:0] o_data_out,
	output wire [DW-1:0] o_data_oe
);

`include "boot_strap_regs.vh"

	genvar g;
	generate
		for (g = 0; g < DW; g = g + 1) begin : lane
			wire used;
			assign used = (i_width == `WIDTH_8) ? (g < 8) :
				(i_width == `WIDTH_16) ? (g < 16) : 1'b1;
			// unused lanes driven low on writes, tristate on reads
			assign o_data_out[g] = used ? i_wdata[g] : 1'b0;
			assign o_data_oe[g] = i_active & i_write;
		end
	endgenerate

endmodule // lane_ctrl

// file: testbench/strap_board.sv
// board strap network: pull-ups with optional pull-downs
`timescale 1ns/10ps
module strap_board (
	input wire [23:0] i_pull_low,
	output wire [23:0] o_exp_address_lines
);
	assign o_exp_address_lines = ~i_pull_low;
endmodule // strap_board

// file: testbench/boot_strap_asserts.sv
// assertions on the boot strap block ports
`timescale 1ns/10ps
`include "boot_strap_regs.vh"
module boot_strap_asserts (
	input wire i_core_clk,
	input wire i_rst_n,
	input wire i_exp_cycle,
	input wire i_exp_write,
	input wire [31:0] i_exp_wdata,
	input wire [31:0] o_exp_data_lines_out,
	input wire [31:0] o_exp_data_lines_oe,
	input wire [1:0] o_bus_width,
	input wire [1:0] o_drive_strength,
	input wire o_pci_66mhz,
	input wire [6:0] o_pci_clk_mhz,
	input wire o_pci_arbiter_enable,
	input wire o_pci_host
);
	wire wr = i_exp_cycle && i_exp_write;
	wire [31:0] d = o_exp_data_lines_out;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_wr; wr; endsequence
	a_rate_code: assert property (o_pci_clk_mhz == (o_pci_66mhz ? `PCI_66_MHZ : `PCI_33_MHZ))
		else $error("pci rate");
	a_lane_drive: assert property (s_wr |-> &o_exp_data_lines_oe)
		else $error("oe low");
	a_lane_float: assert property (!wr |-> o_exp_data_lines_oe == 0)
		else $error("oe high");
	a_byte_lane: assert property (wr && o_bus_width == `WIDTH_8 |-> d[7:0] == i_exp_wdata[7:0])
		else $error("byte lane");
	a_half_lane: assert property (wr && o_bus_width == `WIDTH_16 |-> d[15:0] == i_exp_wdata[15:0])
		else $error("half lane");
	a_full_lane: assert property (wr && o_bus_width == `WIDTH_32 |-> d == i_exp_wdata)
		else $error("full lane");
	a_drive_code: assert property (o_drive_strength != 2'b10)
		else $error("drive code");
	a_cfg_hold: assert property ($changed({o_drive_strength, o_pci_66mhz, o_pci_arbiter_enable,
		o_pci_host}) |-> !$past(i_rst_n, 3)) else $error("config moved");
endmodule // boot_strap_asserts
bind boot_strap_bus_width_config boot_strap_asserts u_chk (.i_core_clk, .i_rst_n, .i_exp_cycle,
	.i_exp_write, .i_exp_wdata, .o_exp_data_lines_out, .o_exp_data_lines_oe, .o_bus_width,
	.o_drive_strength, .o_pci_66mhz, .o_pci_clk_mhz, .o_pci_arbiter_enable, .o_pci_host);

// file: testbench/testbench.sv
// self-checking bench for the boot strap block
`timescale 1ns/10ps
`include "boot_strap_regs.vh"
module testbench;
	logic i_core_clk = 0, i_rst_n = 0, i_reg_wr = 0, i_reg_rd = 0, i_exp_write = 0, i_exp_cycle = 1;
	logic [7:0] i_reg_addr = 0;
	logic [31:0] i_reg_wdata = 0, o_reg_rdata, out, oe;
	logic [23:0] pull_low = 0, strap;
	logic [1:0] o_bus_width, o_drive_strength;
	logic [6:0] o_pci_clk_mhz;
	logic o_pci_66mhz, o_pci_arbiter_enable, o_pci_host;
	int mismatches = 0, samples_checked = 0, cycles = 0;
	logic [16:0] rows [4] = '{{10'h3FF, 7'h7F}, {10'h16B, 7'h29}, {10'h35C, 7'h1E}, {10'h1C8, 7'h40}};
	strap_board board (.i_pull_low(pull_low), .o_exp_address_lines(strap));
	boot_strap_bus_width_config dut (.i_core_clk, .i_rst_n, .i_exp_address_lines(strap),
		.i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_exp_cycle,
		.i_exp_write, .i_exp_wdata(32'h1234_5678), .o_exp_data_lines_out(out),
		.o_exp_data_lines_oe(oe), .o_bus_width, .o_drive_strength, .o_pci_66mhz,
		.o_pci_clk_mhz, .o_pci_arbiter_enable, .o_pci_host);
	always #5 i_core_clk = ~i_core_clk;
	always @(posedge i_core_clk) begin
		i_exp_write <= ~i_exp_write;
		if (i_exp_write) begin
			i_exp_cycle <= ~i_exp_cycle;
		end
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			complete_run;
		end
	end
	task complete_run;
		if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	task boot(input logic [23:0] pl);
		@(posedge i_core_clk) i_rst_n <= 0;
		pull_low <= pl;
		repeat (4) @(posedge i_core_clk);
		i_rst_n <= 1;
		repeat (3) @(posedge i_core_clk);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge i_core_clk) i_reg_addr <= a;
		i_reg_wdata <= v;
		i_reg_wr <= 1;
		@(posedge i_core_clk) i_reg_wr <= 0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge i_core_clk) i_reg_addr <= a;
		i_reg_rd <= 1;
		@(posedge i_core_clk) i_reg_rd <= 0;
		#1;
	endtask
	initial begin
		@(posedge i_core_clk) #1 chk({o_bus_width, o_drive_strength}, 4'hF);
		foreach (rows[k]) begin
			boot(~{14'h3FFF, rows[k][16:7]});
			chk({o_bus_width, o_drive_strength, o_pci_66mhz, o_pci_arbiter_enable, o_pci_host},
				rows[k][6:0]);
			rd(`CFG0_OFFSET);
			chk(o_reg_rdata, {8'h00, 14'h3FFF, rows[k][16:7]});
			chk(o_pci_clk_mhz, rows[k][2] ? `PCI_66_MHZ : `PCI_33_MHZ);
			rd(`STATUS_OFFSET);
			chk(o_reg_rdata, {27'h000_0000, (rows[k][6:5] == 2'b10), rows[k][4:3],
				rows[k][6:5]});
		end
		@(posedge i_core_clk) pull_low <= 24'hFF_FFFF;
		wr(`CFG0_OFFSET, 32'h0000_0000);
		rd(`CFG0_OFFSET);
		chk(o_reg_rdata, {8'h00, 14'h3FFF, 10'h1C8});
		chk(o_pci_arbiter_enable | o_drive_strength, 32'h0000_0000);
		rd(8'h0C);
		chk(o_reg_rdata, 32'h0000_0000);
		wr(`CSCTL_OFFSET, 32'h0000_0005);
		repeat (2) @(posedge i_core_clk);
		#1 chk(o_bus_width, `WIDTH_8);
		chk(oe, {32{i_exp_write & i_exp_cycle}});
		complete_run;
	end
endmodule // testbench
